/* File: logic/sbrg_defs.vh */
/*
 holds: register offsets, field positions, reset values and divide
 ratios of the serial bit-rate generator.
 assumes: included by bare name from the top design file under logic/.
*/
// Contract
// - bit rate is derived from the block's own system clock.
// - receive pin is sampled three times per bit, level by majority vote.
// - async, 8-bit, low speed: rate is clock over 64 times divisor plus one.
// - async, 8-bit, high speed: rate is clock over 16 times divisor plus one.
// - async, 16-bit, low speed: rate is clock over 16 times divisor plus one.
// - clocked mode: clock over 4 times divisor plus one, speed bit ignored.
// - divisor is the low byte alone unless wide select is set, then high and low bytes combined.
// - writing either divisor byte clears the divider timer at once.
// - divider defaults to 8-bit width, high byte ignored until wide select.
`ifndef SBRG_DEFS_VH
`define SBRG_DEFS_VH

// ----------------------------------------------------------------
// register map, word offsets (address bits 4:2), one word each
// ----------------------------------------------------------------
`define SBRG_OFS_TX_CTL 3'h0
`define SBRG_OFS_RX_CTL 3'h1
`define SBRG_OFS_RATE_CTL 3'h2
`define SBRG_OFS_DIV_HIGH 3'h3
`define SBRG_OFS_DIV_LOW 3'h4
`define SBRG_OFS_STATUS 3'h5
`define SBRG_PORT_SEL_BIT 5
`define SBRG_ADDR_USED_MSB 5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SBRG_TX_SYNC_BIT 4
`define SBRG_TX_HIGH_SPEED_BIT 2
`define SBRG_RX_ENABLE_BIT 7
`define SBRG_RATE_INVERT_BIT 5
`define SBRG_RATE_WIDE_BIT 3
`define SBRG_ST_LEVEL_BIT 0
`define SBRG_ST_SER_CLK_BIT 1

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define SBRG_TX_RESET 8'h00
`define SBRG_TX_WMASK 8'hFD
`define SBRG_TX_ROVAL 8'h02
`define SBRG_RX_RESET 8'h00
`define SBRG_RX_WMASK 8'hF8
`define SBRG_RATE_RESET 8'h00
`define SBRG_RATE_WMASK 8'hBB
`define SBRG_RATE_ROVAL 8'h40
`define SBRG_DIV_RESET 8'h00

// ----------------------------------------------------------------
// prescale ratios between timer ticks and bit time
// ----------------------------------------------------------------
`define SBRG_PRE_64 7'h40
`define SBRG_PRE_16 7'h10
`define SBRG_PRE_4 7'h04

`endif

/* File: logic/sbrg_vote.v */
/*
 holds: receive pin synchroniser and three-sample majority vote.
 assumes: i_sample and i_decide are one-cycle strobes on i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module sbrg_vote (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_pin,
    input wire i_invert,
    input wire i_sample,
    input wire i_decide,
    output reg o_level,
    output reg o_valid
);

// ----------------------------------------------------------------
// two-flop synchroniser; first stage feeds only the second
// ----------------------------------------------------------------
reg meta_reg;
reg sync_reg;
reg [2:0] hist_reg;
wire cur;
wire [2:0] trio;

always @(posedge i_mclk) begin
    if (i_sys_rst) begin
        meta_reg <= 1'b1;
        sync_reg <= 1'b1;
    end else begin
        meta_reg <= i_pin;
        sync_reg <= meta_reg;
    end
end

assign cur = sync_reg ^ i_invert;
// the vote must use the three mid-bit samples, not the live pin level
assign trio = i_sample ? {hist_reg[1:0], cur} : hist_reg;

// ----------------------------------------------------------------
// vote; the last sample may land in the deciding cycle
// ----------------------------------------------------------------
always @(posedge i_mclk) begin
    if (i_sys_rst) begin
        hist_reg <= 3'h7;
        o_level <= 1'b1;
        o_valid <= 1'b0;
    end else begin
        o_valid <= i_decide;
        if (i_sample) begin
            hist_reg <= {hist_reg[1:0], cur};
        end
        if (i_decide) begin
            o_level <= (trio[0] & trio[1]) | (trio[0] & trio[2]) | (trio[1] & trio[2]);
        end
    end
end

endmodule

`default_nettype wire

/* File: logic/sbrg_top.v */
/*
 holds: two-port serial bit-rate generator with its control registers
 on an avalon-mm slave, and the receive-pin majority samplers.
 assumes: one clock i_mclk, synchronous active-high reset, receive
 pins asynchronous to i_mclk.
*/
// Design decisions made here: the register addresses and register access over Avalon-MM.
`include "sbrg_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module sbrg_top #(
    parameter PORTS = 2
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    input wire [PORTS-1:0] i_receive_pin,
    output wire [PORTS-1:0] o_bit_tick,
    output wire [PORTS-1:0] o_sample_tick,
    output wire [PORTS-1:0] o_ser_clk,
    output wire [PORTS-1:0] o_rx_level,
    output wire [PORTS-1:0] o_rx_valid
);

// ----------------------------------------------------------------
// bus handshake
// ----------------------------------------------------------------
// every access waits exactly one cycle; read data are registered in
// the wait cycle, while waitrequest is high, so they stand at the accepting edge
reg ack_reg;
wire req;
wire wr_take;
wire [2:0] reg_sel;
wire port_sel;
wire addr_hit;

assign req = i_avs_read | i_avs_write;
assign o_avs_waitrequest = req & ~ack_reg;
assign wr_take = i_avs_write & ack_reg & i_avs_byteenable[0];
assign reg_sel = i_avs_address[4:2];
assign port_sel = i_avs_address[`SBRG_PORT_SEL_BIT];
assign addr_hit = (i_avs_address[1:0] == 2'h0)
    && (i_avs_address[7:`SBRG_ADDR_USED_MSB+1] == 2'h0)
    && (reg_sel <= `SBRG_OFS_STATUS)
    && ({31'h0, port_sel} < PORTS);

always @(posedge i_mclk) begin
    if (i_sys_rst) begin
        ack_reg <= 1'b0;
    end else begin
        ack_reg <= req & ~ack_reg;
    end
end

// ----------------------------------------------------------------
// per-port registers, divider and sampler
// ----------------------------------------------------------------
wire [8*PORTS-1:0] rd_tx;
wire [8*PORTS-1:0] rd_rx;
wire [8*PORTS-1:0] rd_rate;
wire [8*PORTS-1:0] rd_dh;
wire [8*PORTS-1:0] rd_dl;
wire [8*PORTS-1:0] rd_st;

genvar g;
generate
for (g = 0; g < PORTS; g = g + 1) begin : gen_port
    reg [7:0] tx_ctl_reg;
    reg [7:0] rx_ctl_reg;
    reg [7:0] rate_ctl_reg;
    reg [7:0] div_high_reg;
    reg [7:0] div_low_reg;
    reg [15:0] timer_reg;
    reg [6:0] pre_reg;
    reg ser_clk_reg;
    reg tick_reg;
    reg samp_reg;
    wire mine;
    wire div_wr;
    wire sync_mode;
    wire high_speed;
    wire wide;
    wire run;
    wire [15:0] reload;
    wire [6:0] ratio;
    wire [6:0] half;
    wire tick;
    wire last_pre;
    wire in_window;

    assign mine = wr_take && addr_hit && ({31'h0, port_sel} == g);
    assign div_wr = mine && ((reg_sel == `SBRG_OFS_DIV_HIGH)
        || (reg_sel == `SBRG_OFS_DIV_LOW));

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tx_ctl_reg <= `SBRG_TX_RESET;
            rx_ctl_reg <= `SBRG_RX_RESET;
            rate_ctl_reg <= `SBRG_RATE_RESET;
            div_high_reg <= `SBRG_DIV_RESET;
            div_low_reg <= `SBRG_DIV_RESET;
        end else if (mine) begin
            case (reg_sel)
                `SBRG_OFS_TX_CTL: begin
                    tx_ctl_reg <= i_avs_writedata[7:0] & `SBRG_TX_WMASK;
                end
                `SBRG_OFS_RX_CTL: begin
                    rx_ctl_reg <= i_avs_writedata[7:0] & `SBRG_RX_WMASK;
                end
                `SBRG_OFS_RATE_CTL: begin
                    rate_ctl_reg <= i_avs_writedata[7:0] & `SBRG_RATE_WMASK;
                end
                `SBRG_OFS_DIV_HIGH: begin
                    div_high_reg <= i_avs_writedata[7:0];
                end
                `SBRG_OFS_DIV_LOW: begin
                    div_low_reg <= i_avs_writedata[7:0];
                end
                default: begin
                    div_low_reg <= div_low_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    assign sync_mode = tx_ctl_reg[`SBRG_TX_SYNC_BIT];
    assign high_speed = tx_ctl_reg[`SBRG_TX_HIGH_SPEED_BIT];
    assign wide = rate_ctl_reg[`SBRG_RATE_WIDE_BIT];
    // port disabled holds the divider in reset
    assign run = rx_ctl_reg[`SBRG_RX_ENABLE_BIT];

    assign reload = wide ? {div_high_reg, div_low_reg}
        : {8'h00, div_low_reg};

    assign ratio = sync_mode ? `SBRG_PRE_4 :
        (!wide && !high_speed) ? `SBRG_PRE_64 :
        (!wide && high_speed) ? `SBRG_PRE_16 :
        (wide && !high_speed) ? `SBRG_PRE_16 :
        `SBRG_PRE_4;
    assign half = {1'b0, ratio[6:1]};

    // ------------------------------------------------------------
    // free-running timer on the system clock
    // ------------------------------------------------------------
    // no clock-frequency knowledge here: the rate simply scales
    // with i_mclk, so a clock change needs a new divisor
    assign tick = run && (timer_reg == reload);
    assign last_pre = (pre_reg == ratio - 7'h01);
    assign in_window = (pre_reg == half - 7'h01) || (pre_reg == half)
        || (pre_reg == half + 7'h01);

    always @(posedge i_mclk) begin
        if (i_sys_rst || !run || div_wr) begin
            timer_reg <= 16'h0000;
        end else if (tick) begin
            timer_reg <= 16'h0000;
        end else begin
            timer_reg <= timer_reg + 16'h0001;
        end
    end

    // a mode change mid-bit can leave pre_reg above the new ratio;
    // the wrap on any value at or past the end recovers in one bit
    always @(posedge i_mclk) begin
        if (i_sys_rst || !run || div_wr) begin
            pre_reg <= 7'h00;
        end else if (tick) begin
            if (pre_reg >= ratio - 7'h01) begin
                pre_reg <= 7'h00;
            end else begin
                pre_reg <= pre_reg + 7'h01;
            end
        end
    end

    always @(posedge i_mclk) begin
        if (i_sys_rst || !run) begin
            tick_reg <= 1'b0;
            samp_reg <= 1'b0;
            ser_clk_reg <= 1'b0;
        end else begin
            tick_reg <= tick && last_pre;
            samp_reg <= tick && in_window;
            ser_clk_reg <= sync_mode && (pre_reg < half);
        end
    end

    assign o_bit_tick[g] = tick_reg;
    assign o_sample_tick[g] = samp_reg;
    assign o_ser_clk[g] = ser_clk_reg;

    // ------------------------------------------------------------
    // receive pin sampling
    // ------------------------------------------------------------
    sbrg_vote u_vote (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_receive_pin[g]),
        .i_invert(rate_ctl_reg[`SBRG_RATE_INVERT_BIT]),
        .i_sample(samp_reg),
        .i_decide(tick_reg),
        .o_level(o_rx_level[g]),
        .o_valid(o_rx_valid[g])
    );

    // ------------------------------------------------------------
    // read-back images
    // ------------------------------------------------------------
    assign rd_tx[8*g+7:8*g] = tx_ctl_reg | `SBRG_TX_ROVAL;
    assign rd_rx[8*g+7:8*g] = rx_ctl_reg;
    assign rd_rate[8*g+7:8*g] = rate_ctl_reg | `SBRG_RATE_ROVAL;
    assign rd_dh[8*g+7:8*g] = div_high_reg;
    assign rd_dl[8*g+7:8*g] = div_low_reg;
    assign rd_st[8*g+7:8*g] = {6'h00, ser_clk_reg, o_rx_level[g]};
end
endgenerate

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
reg [7:0] rd_byte;
integer p;

always @* begin
    rd_byte = 8'h00;
    for (p = 0; p < PORTS; p = p + 1) begin
        if (addr_hit && ({31'h0, port_sel} == p)) begin
            case (reg_sel)
                `SBRG_OFS_TX_CTL: begin
                    rd_byte = rd_tx[8*p +: 8];
                end
                `SBRG_OFS_RX_CTL: begin
                    rd_byte = rd_rx[8*p +: 8];
                end
                `SBRG_OFS_RATE_CTL: begin
                    rd_byte = rd_rate[8*p +: 8];
                end
                `SBRG_OFS_DIV_HIGH: begin
                    rd_byte = rd_dh[8*p +: 8];
                end
                `SBRG_OFS_DIV_LOW: begin
                    rd_byte = rd_dl[8*p +: 8];
                end
                `SBRG_OFS_STATUS: begin
                    rd_byte = rd_st[8*p +: 8];
                end
                default: begin
                    rd_byte = 8'h00;
                end
            endcase
        end
    end
end

// unmapped reads answer zero; data load while waitrequest is high
always @(posedge i_mclk) begin
    if (i_sys_rst) begin
        o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && !ack_reg) begin
        o_avs_readdata <= {24'h000000, rd_byte};
    end
end

endmodule

`default_nettype wire

/* File: test/sbrg_checker.sv */
/*
 holds: concurrent checks on the ports of the bit-rate generator top.
 assumes: bound to sbrg_top by the testbench; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sbrg_checker #(
    parameter PORTS = 2
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [PORTS-1:0] o_bit_tick,
    input wire logic [PORTS-1:0] o_sample_tick,
    input wire logic [PORTS-1:0] o_rx_valid,
    input wire logic [PORTS-1:0] o_rx_level
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------------------
    // sample count per bit; a write voids the bit, it may restart the prescaler
    // ------------------------------------------------
    logic [3:0] smp_cnt_reg;
    logic wr_seen_reg;
    always @(posedge i_mclk) begin
        if (i_sys_rst || o_bit_tick[0]) begin
            smp_cnt_reg <= 4'h0;
            wr_seen_reg <= i_avs_write & ~i_sys_rst;
        end else begin
            smp_cnt_reg <= smp_cnt_reg + {3'h0, o_sample_tick[0]};
            wr_seen_reg <= wr_seen_reg | i_avs_write;
        end
    end
    AST_WAIT_FIRST: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest)
        else $error("no wait state on a new request");
    AST_ONE_WAIT: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("more than one wait state");
    AST_IDLE: assert property (!(i_avs_read | i_avs_write) |-> !o_avs_waitrequest)
        else $error("waitrequest while idle");
    AST_RD_UPPER: assert property (i_avs_read && !o_avs_waitrequest
        |-> o_avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
    AST_VALID_AFTER: assert property (o_bit_tick[0] |=> o_rx_valid[0])
        else $error("no vote after bit tick");
    AST_VALID_CAUSE: assert property (o_rx_valid[0] |-> $past(o_bit_tick[0]))
        else $error("vote without bit tick");
    AST_THREE_SAMPLES: assert property (o_bit_tick[0] && !wr_seen_reg
        |-> smp_cnt_reg + {3'h0, o_sample_tick[0]} == 4'h3) else $error("not three samples");
    AST_MIN_PERIOD: assert property (o_bit_tick[0] |=> !o_bit_tick[0] [*3])
        else $error("bit ticks closer than four clocks");
    AST_DIV_CLEAR: assert property (i_avs_write && !o_avs_waitrequest
        && i_avs_byteenable[0] && (i_avs_address == 8'h0C || i_avs_address == 8'h10)
        |-> ##2 !o_bit_tick[0] [*3]) else $error("tick too soon after divisor write");
    AST_RESET_OUT: assert property ($fell(i_sys_rst) |-> o_rx_level == {PORTS{1'b1}}
        && o_bit_tick == '0 && o_rx_valid == '0) else $error("outputs not at reset level");
endmodule
`default_nettype wire

/* File: test/sbrg_remote.sv */
/*
 holds: remote serial device sending one bit per generated bit time.
 assumes: i_bit_tick from the generator; LAG delays each new bit (slow party).
*/
`timescale 1ns/1ps
`default_nettype none

module sbrg_remote #(
    parameter LAG = 0
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_bit_tick,
    input wire logic i_next_bit,
    output logic o_pin
);
    logic [3:0] lag_reg;
    logic bit_reg;
    // idle line rests high; the new bit follows each tick, paced by our clock
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_pin <= 1'b1;
            lag_reg <= 4'hF;
        end else if (i_bit_tick) begin
            bit_reg <= i_next_bit;
            lag_reg <= 4'(LAG);
        end else if (lag_reg == 4'h0) begin
            o_pin <= bit_reg;
            lag_reg <= 4'hF;
        end else if (lag_reg != 4'hF) begin
            lag_reg <= lag_reg - 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
/*
 holds: self-checking bench for the two-port bit-rate generator.
 assumes: sbrg_top, sbrg_checker and sbrg_remote compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [7:0] i_avs_address = 8'h00, lfsr_reg = 8'h19;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic inv = 1'b0, rx_on = 1'b0, mp = 1'b0;
    wire [31:0] o_avs_readdata;
    wire o_avs_waitrequest;
    wire [1:0] pin, o_bit_tick, o_sample_tick, o_ser_clk, o_rx_level, o_rx_valid;
    int err_count = 0, total_checks = 0, cyc = 0, last_tick = 0, hi_cnt = 0, n, k;
    int per_q[$], hi_q[$];
    logic [7:0] rd_q[$];
    logic rx_q[$];
    int rt[6] = '{64, 16, 16, 4, 4, 4};
    logic [2:0] md[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

    sbrg_top #(.PORTS(2)) i_sbrg_top (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_receive_pin(pin), .o_bit_tick(o_bit_tick), .o_sample_tick(o_sample_tick),
        .o_ser_clk(o_ser_clk), .o_rx_level(o_rx_level), .o_rx_valid(o_rx_valid));
    sbrg_remote #(.LAG(0)) i_sbrg_remote_0 (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_bit_tick(o_bit_tick[0]), .i_next_bit(lfsr_reg[0]), .o_pin(pin[0]));
    sbrg_remote #(.LAG(3)) i_sbrg_remote_1 (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_bit_tick(o_bit_tick[1]), .i_next_bit(lfsr_reg[1]), .o_pin(pin[1]));

    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        do @(posedge i_mclk); while (o_avs_waitrequest);
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 8'h00);
    endtask

    // measure one whole bit period; the first after a change may be partial
    // clocked mode keeps the serial clock high for the first half of the bit
    task automatic check_rate(input int r, input int nv, input logic s);
        @(posedge i_mclk iff o_bit_tick[mp]);
        #1 per_q.push_back(r * (nv + 1));
        hi_q.push_back(s ? 2 * (nv + 1) : 0);
        @(posedge i_mclk iff o_bit_tick[mp]);
        #1;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // result watcher: oldest note against what appears
    // ------------------------------------------------
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        lfsr_reg <= lfsr(lfsr_reg);
        if (i_avs_read && !o_avs_waitrequest && rd_q.size() > 0) begin
            check(o_avs_readdata, rd_q.pop_front());
        end
        if (o_bit_tick[mp]) begin
            if (per_q.size() > 0) begin
                check(cyc - last_tick, per_q.pop_front());
            end
            if (hi_q.size() > 0) begin
                check(hi_cnt, hi_q.pop_front());
            end
            hi_cnt = 0;
            last_tick = cyc;
        end
        hi_cnt = hi_cnt + o_ser_clk[mp];
        if (rx_on && o_rx_valid[0] && rx_q.size() > 0) begin
            check(o_rx_level[0], rx_q.pop_front());
        end
        if (rx_on && o_bit_tick[0]) begin
            rx_q.push_back(pin[0] ^ inv);
        end
    end

    initial begin
        repeat (60000) @(posedge i_mclk);
        err_count++;
        finish_test;
    end

    initial begin
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(8'h00, 8'h02);
        rd(8'h08, 8'h40);
        rd(8'h0C, 8'h00);
        rd(8'h18, 8'h00);
        rd(8'h14, 8'h01);
        bus(1'b1, 8'h00, 8'hFF);
        rd(8'h00, 8'hFF);
        bus(1'b1, 8'h08, 8'hFF);
        rd(8'h08, 8'hFB);
        bus(1'b1, 8'h04, 8'hFF);
        rd(8'h04, 8'hF8);
        bus(1'b1, 8'h18, 8'hFF);
        rd(8'h18, 8'h00);
        i_avs_byteenable <= 4'h0;
        bus(1'b1, 8'h10, 8'h55);
        i_avs_byteenable <= 4'hF;
        rd(8'h10, 8'h00);
        // every mode; high byte 01 must count only with the wide divider
        for (int m = 0; m < 6; m++) begin
            n = 2 + lfsr_reg[2:0];
            bus(1'b1, 8'h00, {3'h0, md[m][2], 1'b0, md[m][0], 2'h0});
            bus(1'b1, 8'h08, {4'h0, md[m][1], 3'h0});
            bus(1'b1, 8'h0C, 8'h01);
            bus(1'b1, 8'h10, n[7:0]);
            rd(8'h0C, 8'h01);
            bus(1'b1, 8'h04, 8'h80);
            check_rate(rt[m], md[m][1] ? 256 + n : n, md[m][2]);
        end
        // slow count cut short by a new divisor
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h08, 8'h00);
        bus(1'b1, 8'h10, 8'hC8);
        repeat (100) @(posedge i_mclk);
        bus(1'b1, 8'h10, 8'h02);
        k = 0;
        while (!o_bit_tick[0] && k < 400) begin
            @(posedge i_mclk);
            k++;
        end
        check(k > 196, 1'b0);
        // majority vote of the remote's random bits, plain then inverted
        bus(1'b1, 8'h00, 8'h04);
        bus(1'b1, 8'h10, 8'h03);
        check_rate(16, 3, 1'b0);
        for (int p = 0; p < 2; p++) begin
            rx_q.delete();
            rx_on = 1'b1;
            repeat (12) @(posedge i_mclk iff o_rx_valid[0]);
            #1 rx_on = 1'b0;
            bus(1'b1, 8'h08, 8'h20);
            inv = 1'b1;
            repeat (2) @(posedge i_mclk iff o_rx_valid[0]);
            #1;
        end
        // second port, slow remote
        mp = 1'b1;
        bus(1'b1, 8'h20, 8'h04);
        bus(1'b1, 8'h30, 8'h05);
        bus(1'b1, 8'h24, 8'h80);
        check_rate(16, 5, 1'b0);
        mp = 1'b0;
        @(posedge i_mclk);
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(8'h10, 8'h00);
        rd(8'h00, 8'h02);
        repeat (3) @(posedge i_mclk);
        finish_test;
    end
endmodule

bind sbrg_top sbrg_checker #(.PORTS(PORTS)) i_sbrg_checker (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_bit_tick(o_bit_tick), .o_sample_tick(o_sample_tick), .o_rx_valid(o_rx_valid),
    .o_rx_level(o_rx_level));
`default_nettype wire
